// file: msq_acq_model.sv
// Acquisition engine model: one done pulse a fixed delay after the latest start
`timescale 1ns/1ps
`default_nettype none
module msq_acq_model #(
   parameter int DLY = 20                   // Acquisition length in cycles
) (
   input  wire logic        clk_sys,        // System clock
   input  wire logic        nrst,           // Reset, active low
   input  wire logic        acq_start,      // Start pulse from the sequencer
   output logic             acq_done,       // Completion pulse
   output logic             acq_ok,         // Result valid
   output logic [63:0]      acq_mant,       // Result mantissa, held
   output logic [7:0]       acq_exp,        // Result exponent, held
   output logic [3:0]       acq_digits      // Digits from resolution
);
   int cnt = 0;                             // Cycles left, zero when idle
   // Count down a running acquisition, restart on a new start
   always_ff @(posedge clk_sys) begin
      acq_done <= nrst && (cnt == 1);
      cnt      <= !nrst ? 0 : acq_start ? DLY : (cnt > 0) ? cnt - 1 : 0;
   end
   assign acq_ok     = 1'b1;
   assign acq_mant   = 64'h0000_0000_0001_E240;
   assign acq_exp    = 8'h05;
   assign acq_digits = 4'h9;
endmodule
`default_nettype wire

// file: msq_conf_store.sv
// Stored answer of the configuration query, cleared only at power-on
`timescale 1ns/1ps
`default_nettype none
module msq_conf_store #(
   parameter int PW = 32               // Parameter width
) (
   input  wire logic          clk_sys,   // System clock
   input  wire logic          nrst,      // Power-on reset, active low
   input  wire logic          wr,        // Store a new answer
   input  wire logic [3:0]    func,      // Function code
   input  wire logic [PW-1:0] p1,        // First parameter
   input  wire logic [PW-1:0] p2,        // Second parameter
   input  wire logic [3:0]    chan,      // Channel list
   output logic               valid_q,   // An answer has been stored
   output logic [3:0]         func_q,    // Stored function
   output logic [PW-1:0]      p1_q,      // Stored first parameter
   output logic [PW-1:0]      p2_q,      // Stored second parameter
   output logic [3:0]         chan_q     // Stored channel list
);

   // Only configure or measure writes; reset and recall never reach here
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         valid_q <= 1'b0;
         func_q  <= 4'h0;
         p1_q    <= '0;
         p2_q    <= '0;
         chan_q  <= 4'h0;
      end else if (wr) begin
         valid_q <= 1'b1;
         func_q  <= func;
         p1_q    <= p1;
         p2_q    <= p2;
         chan_q  <= chan;
      end
   end

endmodule
`default_nettype wire

// file: msq_pkg.sv
// Shared constants and types of the measurement instruction sequencer
package msq_pkg;

   // Commands handed over by the command parser
   typedef enum logic [3:0] {
      CMD_CONF   = 4'h0,  // Configure function, no acquisition
      CMD_INIT   = 4'h1,  // Immediate initiate
      CMD_FETCH  = 4'h2,  // Fetch query
      CMD_READ   = 4'h3,  // Initiate then fetch
      CMD_MEAS   = 4'h4,  // Configure, initiate, fetch
      CMD_CONFQ  = 4'h5,  // Configuration query
      CMD_RST    = 4'h6,  // Reset command
      CMD_RECALL = 4'h7,  // State recall
      CMD_SENSFN = 4'h8   // Plain sense-function change
   } msq_cmd_e;

   // Measurement functions; the duty, rise and fall codes stand for the short names
   typedef enum logic [3:0] {
      FN_FREQ  = 4'h0, FN_PER   = 4'h1, FN_RATIO = 4'h2, FN_VMAX  = 4'h3,
      FN_VMIN  = 4'h4, FN_PTP   = 4'h5, FN_DCYC  = 4'h6, FN_FTIM  = 4'h7,
      FN_RTIM  = 4'h8, FN_NWID  = 4'h9, FN_PWID  = 4'hA, FN_PHAS  = 4'hB,
      FN_TINT  = 4'hC, FN_TOTC  = 4'hD, FN_TOTT  = 4'hE
   } msq_func_e;

   // Sequencer states, Gray along idle, hold-off, fetch
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_WAIT  = 2'h1,
      ST_FETCH = 2'h3
   } msq_state_e;

   // Error codes as 16-bit two's complement
   localparam logic [15:0] ERR_STALE     = 16'hFF1A;  // -230 data corrupt or stale
   localparam logic [15:0] ERR_TOT_BUSY  = 16'hFF23;  // -221 settings conflict
   localparam logic [15:0] ERR_NO_CONFIG = 16'hFF1A;  // Query before any configure

   // Not-a-number as decimal mantissa and exponent: 991E35 = 9.91E37
   localparam logic [63:0] NAN_MANT = 64'h0000_0000_0000_03DF;
   localparam logic [7:0]  NAN_EXP  = 8'h23;

   // Significant digit limits of the ASCII form
   localparam logic [3:0] DIG_MIN = 4'h1;
   localparam logic [3:0] DIG_MAX = 4'hF;

   // Channel entry codes; a channel list is two 2-bit entries
   localparam logic [1:0] CH_NONE = 2'h0;
   localparam logic [1:0] CH_1    = 2'h1;
   localparam logic [1:0] CH_2    = 2'h2;

   // Parameter slot reset value and count of parameter slots
   localparam logic [31:0] PARAM_RST = 32'h0000_0000;
   localparam int          NPARAM    = 2;

endpackage

// file: msq_resp_fmt.sv
// Result formatter: not-a-number substitution, digit clamp, output form
`timescale 1ns/1ps
`default_nettype none
module msq_resp_fmt (
   input  wire logic        clk_sys,     // System clock
   input  wire logic        nrst,        // Synchronous reset, active low
   input  wire logic        load,        // Emit one numeric answer
   input  wire logic        nan,         // Answer is not-a-number
   input  wire logic [63:0] mant,        // Result mantissa
   input  wire logic [7:0]  expo,        // Result decimal exponent
   input  wire logic [3:0]  digits,      // Digits from the resolution
   input  wire logic        fmt_real,    // Real format selected
   output logic             num_valid_q, // One-cycle answer strobe
   output logic [63:0]      num_mant_q,  // Answer mantissa
   output logic [7:0]       num_exp_q,   // Answer exponent
   output logic [3:0]       num_dig_q,   // Significant digits, 1 to 15
   output logic             num_real_q   // Answer uses the real form
);

   // Clamp of the digit count into its legal span
   wire logic [3:0] dig_clamp = (digits < msq_pkg::DIG_MIN) ? msq_pkg::DIG_MIN : digits;

   // Register the answer with the format in force at that moment
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         num_valid_q <= 1'b0;
         num_mant_q  <= '0;
         num_exp_q   <= '0;
         num_dig_q   <= msq_pkg::DIG_MIN;
         num_real_q  <= 1'b0;
      end else begin
         num_valid_q <= load;
         if (load) begin
            num_mant_q <= nan ? msq_pkg::NAN_MANT : mant;
            num_exp_q  <= nan ? msq_pkg::NAN_EXP : expo;
            num_dig_q  <= nan ? msq_pkg::DIG_MAX : dig_clamp;
            num_real_q <= fmt_real;
         end
      end
   end

endmodule
`default_nettype wire

// file: msq_seq.sv
// Measurement instruction sequencer: configure, initiate, fetch, query
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Measure equals configure, initiate, fetch, then queue
// - Read is initiate followed by fetch
// - Fetch repeats on one data set
// - Unexpected parameter ignored, command warning set
// - No valid result gives NaN, error -230
// - Configure sets up and defaults, no acquisition
// - Omitted or DEFault parameters take function defaults
// - Configure turns math, statistics, limits off
// - No absolute level: auto-trigger unless peaks/totalize
// - Query reports last configure or measure only
// - Query answer: function, parameters, channels, short names
// - Reset, recall, sense change keep query answer
// - Query before any configure: error, empty string
// - Named fetch needs same or derivable type
// - Unnamed fetch uses last used function
// - Fetch while measuring stalls later commands
// - ASCII results carry 1 to 15 digits
// - Fetch in running auto totalize: NaN, -221
// - Channel list: one entry, or two entries
// - Result encoding follows output format
module msq_seq #(
   parameter int PW = 32                      // Parameter width
) (
   input  wire logic          clk_sys,         // System clock, 20 MHz
   input  wire logic          nrst,            // Power-on reset, active low
   input  wire logic          dev_clear,       // Device clear, releases hold-off
   input  wire logic          cmd_valid,       // Command offered
   output logic               cmd_ready,       // Command taken when high
   input  wire logic [3:0]    cmd_op,          // Command code
   input  wire logic          cmd_fn_given,    // Function named in command
   input  wire logic [3:0]    cmd_fn,          // Named function
   input  wire logic [1:0]    cmd_pmask,       // Parameter given, per slot
   input  wire logic [PW-1:0] cmd_p1,          // First parameter
   input  wire logic [PW-1:0] cmd_p2,          // Second parameter
   input  wire logic          cmd_abs_level,   // Absolute trigger level given
   input  wire logic          cmd_extra,       // Unexpected parameter seen
   input  wire logic [3:0]    cmd_chan,        // Channel list, zero when omitted
   input  wire logic          fmt_real,        // Output format is real
   output logic               acq_start,       // Start one acquisition
   input  wire logic          acq_done,        // Acquisition finished
   input  wire logic          acq_ok,          // Finished acquisition is valid
   input  wire logic [63:0]   acq_mant,        // Result mantissa
   input  wire logic [7:0]    acq_exp,         // Result exponent
   input  wire logic [3:0]    acq_digits,      // Digits from resolution
   output logic               setup_q,         // Function set-up pulse
   output logic [3:0]         setup_fn_q,      // Function being set up
   output logic [PW-1:0]      setup_p1_q,      // First parameter after defaults
   output logic [PW-1:0]      setup_p2_q,      // Second parameter after defaults
   output logic [3:0]         setup_chan_q,    // Channel list after defaults
   output logic               feat_off_q,      // Math, statistics, limits off
   output logic               autotrig_q,      // Enable and run auto-trigger
   output logic               warn_q,          // Command warning bit pulse
   output logic               err_q,           // Error log pulse
   output logic [15:0]        err_code_q,      // Error code
   output logic               num_valid,       // Numeric answer strobe
   output logic [63:0]        num_mant,        // Numeric answer mantissa
   output logic [7:0]         num_exp,         // Numeric answer exponent
   output logic [3:0]         num_dig,         // Significant digits
   output logic               num_real,        // Real form flag
   output logic [3:0]         num_fn_q,        // Function of the answer
   output logic [3:0]         num_src_fn_q,    // Stored type it derives from
   output logic               str_valid_q,     // Query answer strobe
   output logic               str_empty_q,     // Query answer is empty
   output logic [3:0]         str_fn_q,        // Query function
   output logic [PW-1:0]      str_p1_q,        // Query first parameter
   output logic [PW-1:0]      str_p2_q,        // Query second parameter
   output logic [3:0]         str_chan_q       // Query channel list
);

   // Peak voltage family
   function automatic logic is_peak(input logic [3:0] f);
      is_peak = (f == msq_pkg::FN_VMAX) || (f == msq_pkg::FN_VMIN) || (f == msq_pkg::FN_PTP);
   endfunction

   // Same type, or frequency-period, or within the peaks family
   function automatic logic derivable(input logic [3:0] want, input logic [3:0] have);
      logic fp_w;
      logic fp_h;
      fp_w = (want == msq_pkg::FN_FREQ) || (want == msq_pkg::FN_PER);
      fp_h = (have == msq_pkg::FN_FREQ) || (have == msq_pkg::FN_PER);
      derivable = (want == have) || (fp_w && fp_h) || (is_peak(want) && is_peak(have));
   endfunction

   // Two-channel functions measure between two entries
   function automatic logic two_chan(input logic [3:0] f);
      two_chan = (f == msq_pkg::FN_RATIO) || (f == msq_pkg::FN_PHAS) || (f == msq_pkg::FN_TINT);
   endfunction

   // State, flags and remembered functions
   msq_pkg::msq_state_e st_q, st_d;                // Sequencer state
   logic       busy_q;                             // Measurement in progress
   logic       valid_q;                            // Valid result held
   logic [3:0] meas_fn_q;                          // Type of the acquired data
   logic [3:0] last_fn_q;                          // Last function used
   logic [3:0] pend_fn_q;                          // Function of a stalled fetch
   logic       str_have;                           // A configuration answer is stored

   // Decode of the offered command
   wire logic take      = cmd_valid && cmd_ready;
   wire logic is_conf   = take && (cmd_op == msq_pkg::CMD_CONF);
   wire logic is_meas   = take && (cmd_op == msq_pkg::CMD_MEAS);
   wire logic is_init   = take && (cmd_op == msq_pkg::CMD_INIT);
   wire logic is_fetch  = take && (cmd_op == msq_pkg::CMD_FETCH);
   wire logic is_read   = take && (cmd_op == msq_pkg::CMD_READ);
   wire logic is_confq  = take && (cmd_op == msq_pkg::CMD_CONFQ);
   wire logic do_config = is_conf || is_meas;
   wire logic [3:0] fn_sel = cmd_fn_given ? cmd_fn : last_fn_q;
   wire logic tot_auto  = (meas_fn_q == msq_pkg::FN_TOTC);                          // Auto-armed totalize
   wire logic read_tot  = is_read && (last_fn_q == msq_pkg::FN_TOTC);
   wire logic fetch_tot = is_fetch && busy_q && tot_auto;
   wire logic fetch_now = is_fetch && !busy_q;
   wire logic start_acq = (is_init && !busy_q) || is_meas || (is_read && !read_tot);
   wire logic stall_go  = start_acq && !is_init || (is_fetch && busy_q && !tot_auto);
   wire logic fin_fetch = (st_q == msq_pkg::ST_FETCH);

   // Defaults substituted for omitted parameters and channels
   wire logic [PW-1:0] p1_dflt = '0;
   wire logic [PW-1:0] p2_dflt = '0;
   wire logic [3:0] chan_dflt = two_chan(cmd_fn) ? {msq_pkg::CH_2, msq_pkg::CH_1}
                                                 : {msq_pkg::CH_NONE, msq_pkg::CH_1};
   wire logic [PW-1:0] p1_eff = cmd_pmask[0] ? cmd_p1 : p1_dflt;
   wire logic [PW-1:0] p2_eff = cmd_pmask[1] ? cmd_p2 : p2_dflt;
   wire logic [3:0] chan_eff = (cmd_chan == 4'h0) ? chan_dflt : cmd_chan;
   wire logic auto_ok = !cmd_abs_level && !is_peak(cmd_fn)
                        && (cmd_fn != msq_pkg::FN_TOTC) && (cmd_fn != msq_pkg::FN_TOTT);

   // Fetch verdict, either taken now or at the end of a stall
   wire logic [3:0] f_fn    = fin_fetch ? pend_fn_q : fn_sel;
   wire logic f_go          = fin_fetch || fetch_now;
   wire logic f_ok          = valid_q && derivable(f_fn, meas_fn_q);
   wire logic nan_tot       = fetch_tot || read_tot;
   wire logic fmt_load      = f_go || nan_tot;
   wire logic fmt_nan       = nan_tot || !f_ok;

   // Hold-off: no command is taken while stalled
   assign cmd_ready = (st_q == msq_pkg::ST_IDLE);
   assign acq_start = start_acq;

   // Next state of the sequencer
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         msq_pkg::ST_IDLE:  if (stall_go) st_d = msq_pkg::ST_WAIT;
         msq_pkg::ST_WAIT:  if (dev_clear) st_d = msq_pkg::ST_IDLE;
                            else if (acq_done) st_d = msq_pkg::ST_FETCH;
         msq_pkg::ST_FETCH: st_d = msq_pkg::ST_IDLE;
         default:           st_d = msq_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst) st_q <= msq_pkg::ST_IDLE;
      else       st_q <= st_d;
   end

   // Busy and valid flags; a new start wins over a completion
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         busy_q  <= 1'b0;
         valid_q <= 1'b0;
      end else if (start_acq) begin
         busy_q  <= 1'b1;
         valid_q <= 1'b0;
      end else if (acq_done && busy_q) begin
         busy_q  <= 1'b0;
         valid_q <= acq_ok;
      end else if (do_config) begin
         valid_q <= 1'b0;
      end
   end

   // Data type, last used function and the function of a stalled fetch
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         meas_fn_q <= msq_pkg::FN_FREQ;
         last_fn_q <= msq_pkg::FN_FREQ;
         pend_fn_q <= msq_pkg::FN_FREQ;
      end else begin
         if (start_acq) meas_fn_q <= (is_meas || cmd_fn_given) && !is_init ? cmd_fn : last_fn_q;
         if (do_config || ((is_read || is_fetch) && cmd_fn_given)) last_fn_q <= cmd_fn;
         if (take) pend_fn_q <= fn_sel;
      end
   end

   // Set-up strobes of configure and measure
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         setup_q      <= 1'b0;
         setup_fn_q   <= 4'h0;
         setup_p1_q   <= msq_pkg::PARAM_RST;
         setup_p2_q   <= msq_pkg::PARAM_RST;
         setup_chan_q <= 4'h0;
         feat_off_q   <= 1'b0;
         autotrig_q   <= 1'b0;
         warn_q       <= 1'b0;
      end else begin
         setup_q    <= do_config;
         feat_off_q <= do_config;
         autotrig_q <= do_config && auto_ok;
         warn_q     <= take && cmd_extra;
         if (do_config) begin
            setup_fn_q   <= cmd_fn;
            setup_p1_q   <= p1_eff;
            setup_p2_q   <= p2_eff;
            setup_chan_q <= chan_eff;
         end
      end
   end

   // Error log: totalize conflict, stale data, missing configuration
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         err_q      <= 1'b0;
         err_code_q <= 16'h0000;
      end else begin
         err_q <= nan_tot || (f_go && !f_ok) || (is_confq && !str_have);
         if (nan_tot)               err_code_q <= msq_pkg::ERR_TOT_BUSY;
         else if (f_go && !f_ok)    err_code_q <= msq_pkg::ERR_STALE;
         else if (is_confq && !str_have) err_code_q <= msq_pkg::ERR_NO_CONFIG;
      end
   end

   // Function tags of each numeric answer
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         num_fn_q     <= 4'h0;
         num_src_fn_q <= 4'h0;
      end else if (fmt_load) begin
         num_fn_q     <= f_fn;
         num_src_fn_q <= meas_fn_q;
      end
   end

   // Stored configuration answer
   logic [3:0]      cs_fn;
   logic [PW-1:0]   cs_p1;
   logic [PW-1:0]   cs_p2;
   logic [3:0]      cs_chan;
   msq_conf_store #(.PW(PW)) u_store (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .wr      (do_config),
      .func    (cmd_fn),
      .p1      (p1_eff),
      .p2      (p2_eff),
      .chan    (chan_eff),
      .valid_q (str_have),
      .func_q  (cs_fn),
      .p1_q    (cs_p1),
      .p2_q    (cs_p2),
      .chan_q  (cs_chan)
   );

   // Configuration query answer, empty before the first configure
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         str_valid_q <= 1'b0;
         str_empty_q <= 1'b0;
         str_fn_q    <= 4'h0;
         str_p1_q    <= '0;
         str_p2_q    <= '0;
         str_chan_q  <= 4'h0;
      end else begin
         str_valid_q <= is_confq;
         if (is_confq) begin
            str_empty_q <= !str_have;
            str_fn_q    <= cs_fn;
            str_p1_q    <= cs_p1;
            str_p2_q    <= cs_p2;
            str_chan_q  <= cs_chan;
         end
      end
   end

   // Numeric answer path
   msq_resp_fmt u_fmt (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .load        (fmt_load),
      .nan         (fmt_nan),
      .mant        (acq_mant),
      .expo        (acq_exp),
      .digits      (acq_digits),
      .fmt_real    (fmt_real),
      .num_valid_q (num_valid),
      .num_mant_q  (num_mant),
      .num_exp_q   (num_exp),
      .num_dig_q   (num_dig),
      .num_real_q  (num_real)
   );

   // Stall then answer after the acquisition ends
   sequence s_stall;
      (st_q == msq_pkg::ST_WAIT) ##1 (st_q == msq_pkg::ST_WAIT);
   endsequence

   AST_HOLD_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q == msq_pkg::ST_WAIT) |-> !cmd_ready)
      else $error("Command taken during hold-off");
   AST_DONE_ANSWERS: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q == msq_pkg::ST_WAIT && acq_done && !dev_clear) |-> ##2 num_valid)
      else $error("No answer after acquisition end");
   AST_CONF_NO_ACQ: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_conf |-> !acq_start)
      else $error("Configure started an acquisition");
   AST_CONF_FEATOFF: assert property (@(posedge clk_sys) disable iff (!nrst)
      do_config |=> feat_off_q && setup_q)
      else $error("Configure left features on");
   AST_WARN: assert property (@(posedge clk_sys) disable iff (!nrst)
      (take && cmd_extra) |=> warn_q && !$past(busy_q) || warn_q)
      else $error("Command warning not raised");
   AST_NAN_STALE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (fetch_now && !valid_q) |=> err_q && err_code_q == msq_pkg::ERR_STALE
                                  && num_valid && num_mant == msq_pkg::NAN_MANT)
      else $error("Stale fetch not answered with not-a-number");
   AST_TOT_BUSY: assert property (@(posedge clk_sys) disable iff (!nrst)
      fetch_tot |=> err_q && err_code_q == msq_pkg::ERR_TOT_BUSY && num_valid && num_exp == msq_pkg::NAN_EXP)
      else $error("Totalize fetch conflict missed");
   AST_EMPTY_QUERY: assert property (@(posedge clk_sys) disable iff (!nrst)
      (is_confq && !str_have) |=> str_valid_q && str_empty_q && err_q)
      else $error("Early query not empty with error");
   AST_FETCH_REPEAT: assert property (@(posedge clk_sys) disable iff (!nrst)
      fetch_now |-> !acq_start)
      else $error("Fetch started a new acquisition");
   AST_STALL_KEEPS: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_stall |-> busy_q || $past(dev_clear) || $past(acq_done))
      else $error("Stall without running measurement");
   AST_DIGITS: assert property (@(posedge clk_sys) disable iff (!nrst)
      num_valid |-> num_dig >= msq_pkg::DIG_MIN)
      else $error("Digit count out of range");
   AST_TOT_NO_AUTO: assert property (@(posedge clk_sys) disable iff (!nrst)
      (do_config && (cmd_fn == msq_pkg::FN_TOTC || cmd_fn == msq_pkg::FN_TOTT)) |=> !autotrig_q)
      else $error("Auto-trigger run for totalize");

endmodule
`default_nettype wire

// file: tb_msq_seq.sv
// Self-checking testbench of the measurement instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_msq_seq;
   logic clk_sys = 0, nrst = 0, dev_clear = 0, cmd_valid = 0, cmd_fn_given = 0, cmd_abs_level = 0, cmd_extra = 0;
   logic fmt_real = 0, cmd_ready, acq_start, acq_done, acq_ok, setup_q, feat_off_q, autotrig_q, warn_q, err_q;
   logic num_valid, num_real, str_valid_q, str_empty_q;
   logic [3:0]  cmd_op = 0, cmd_fn = 0, cmd_chan = 0, setup_fn_q, setup_chan_q, num_dig, num_fn_q, num_src_fn_q;
   logic [3:0]  str_fn_q, acq_digits;
   logic [1:0]  cmd_pmask = 0;
   logic [31:0] cmd_p1 = 0, cmd_p2 = 0;
   logic [15:0] err_code_q;
   logic [63:0] num_mant, acq_mant;
   logic [7:0]  num_exp, acq_exp;
   int bad_count = 0, tests_run = 0, starts = 0;
   msq_seq msq_seq_inst (.clk_sys, .nrst, .dev_clear, .cmd_valid, .cmd_ready, .cmd_op, .cmd_fn_given, .cmd_fn,
      .cmd_pmask, .cmd_p1, .cmd_p2, .cmd_abs_level, .cmd_extra, .cmd_chan, .fmt_real, .acq_start, .acq_done, .acq_ok,
      .acq_mant, .acq_exp, .acq_digits, .setup_q, .setup_fn_q, .setup_p1_q(), .setup_p2_q(), .setup_chan_q,
      .feat_off_q, .autotrig_q, .warn_q, .err_q, .err_code_q, .num_valid, .num_mant, .num_exp, .num_dig, .num_real,
      .num_fn_q, .num_src_fn_q, .str_valid_q, .str_empty_q, .str_fn_q, .str_p1_q(), .str_p2_q(), .str_chan_q());
   msq_acq_model msq_acq_model_inst (.clk_sys, .nrst, .acq_start, .acq_done, .acq_ok, .acq_mant, .acq_exp,
      .acq_digits);
   initial forever #25 clk_sys = ~clk_sys;
   // Count acquisitions started
   always @(posedge clk_sys) if (acq_start === 1'b1) starts++;
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Offer a command, hold it until taken, return just after the taking edge
   task automatic send(input logic [3:0] o, input logic [3:0] f, input logic g, input logic x);
      @(posedge clk_sys);
      cmd_valid <= 1; cmd_op <= o; cmd_fn <= f; cmd_fn_given <= g; cmd_extra <= x;
      #1;
      while (cmd_ready !== 1'b1) begin @(posedge clk_sys); #1; end
      @(posedge clk_sys);
      cmd_valid <= 0; cmd_extra <= 0;
      #1;
   endtask
   // Wait for a numeric answer under a bounded count
   task automatic wait_num();
      for (int i = 0; i < 100 && num_valid !== 1'b1; i++) begin @(posedge clk_sys); #1; end
      chk(num_valid, 1);
   endtask
   // Query and fetch before any configure
   task automatic scn_early();
      send(msq_pkg::CMD_CONFQ, 0, 0, 0);
      chk({str_valid_q, str_empty_q, err_q, err_code_q}, {3'b111, msq_pkg::ERR_NO_CONFIG});
      send(msq_pkg::CMD_FETCH, 0, 0, 0);
      chk({num_valid, err_q, err_code_q, num_mant}, {2'b11, msq_pkg::ERR_STALE, msq_pkg::NAN_MANT});
   endtask
   // Configure, measure, named fetch, then a read without a function
   task automatic scn_meas();
      send(msq_pkg::CMD_CONF, msq_pkg::FN_FREQ, 1, 1);
      chk({setup_q, feat_off_q, autotrig_q, warn_q, setup_fn_q, setup_chan_q, starts}, {4'hF, 8'h01, 32'd0});
      send(msq_pkg::CMD_MEAS, msq_pkg::FN_PER, 1, 0);
      chk({cmd_ready, setup_q}, 2'b01);
      wait_num();
      chk({num_mant, num_dig, num_fn_q, starts}, {acq_mant, 8'h91, 32'd1});
      send(msq_pkg::CMD_FETCH, msq_pkg::FN_FREQ, 1, 0);
      chk({num_valid, num_fn_q, num_src_fn_q, starts}, {9'h101, 32'd1});
      @(posedge clk_sys);
      fmt_real <= 1;
      send(msq_pkg::CMD_READ, msq_pkg::FN_PER, 0, 0);
      wait_num();
      chk({num_real, num_fn_q, starts}, {5'h10, 32'd2});
   endtask
   // Reset, recall and sense change leave the query answer alone
   task automatic scn_keep();
      send(msq_pkg::CMD_RST, 0, 0, 0);
      send(msq_pkg::CMD_RECALL, 0, 0, 0);
      send(msq_pkg::CMD_SENSFN, msq_pkg::FN_TINT, 1, 0);
      send(msq_pkg::CMD_CONFQ, 0, 0, 0);
      chk({str_valid_q, str_empty_q, err_q, str_fn_q}, 7'h41);
   endtask
   // Totalize: no auto-trigger, fetch and read while counting answer -221
   task automatic scn_tot();
      send(msq_pkg::CMD_CONF, msq_pkg::FN_TOTC, 1, 0);
      chk({setup_q, autotrig_q}, 2'b10);
      send(msq_pkg::CMD_INIT, 0, 0, 0);
      send(msq_pkg::CMD_FETCH, 0, 0, 0);
      chk({num_valid, err_q, err_code_q, num_exp}, {2'b11, msq_pkg::ERR_TOT_BUSY, msq_pkg::NAN_EXP});
      send(msq_pkg::CMD_READ, 0, 0, 0);
      chk({num_valid, err_q, err_code_q, num_exp}, {2'b11, msq_pkg::ERR_TOT_BUSY, msq_pkg::NAN_EXP});
      chk(starts, 3);
   endtask
   // Read stall released by device clear, then a stalled fetch answers
   task automatic scn_clear();
      send(msq_pkg::CMD_CONF, msq_pkg::FN_RATIO, 1, 0);
      chk({autotrig_q, setup_chan_q}, 5'h19);
      send(msq_pkg::CMD_READ, 0, 0, 0);
      chk(cmd_ready, 0);
      @(posedge clk_sys);
      dev_clear <= 1;
      @(posedge clk_sys);
      dev_clear <= 0;
      #1;
      chk({cmd_ready, num_valid}, 2'b10);
      send(msq_pkg::CMD_FETCH, 0, 0, 0);
      chk(cmd_ready, 0);
      wait_num();
      chk({num_fn_q, num_exp, starts}, {msq_pkg::FN_RATIO, acq_exp, 32'd4});
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1;
      scn_early();
      scn_meas();
      scn_keep();
      scn_tot();
      scn_clear();
      end_sim();
   end
   // Watchdog far beyond the expected run length
   initial begin
      #200us;
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
